//--- common/psm_pkg.sv
// Constants, offsets and field layout of the pattern sync and error monitor.
package psm_pkg;

   localparam int CLK_PERIOD_NS = 10;
   localparam int INTERVAL_NS = 1000000;
   localparam int INTERVAL_CYC = INTERVAL_NS / CLK_PERIOD_NS;
   localparam int CLK_LOSS_NS = 1000;
   localparam int CLK_LOSS_CYC = CLK_LOSS_NS / CLK_PERIOD_NS;

   localparam logic [12:0] MIN_EFF_LEN = 13'd512;
   localparam logic [7:0] QUICK_GAIN_BITS = 8'd32;
   localparam logic [7:0] SYNC_WIN_BITS = 8'd128;
   localparam logic [7:0] SYNC_LOSS_ERRS = 8'd16;
   localparam int PAT_WORDS = 64;
   localparam int PAT_AW = 6;

   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_FRAME_POS = 8'h04;
   localparam logic [7:0] OFS_PAT_LEN = 8'h08;
   localparam logic [7:0] OFS_ROW_LEN = 8'h0c;
   localparam logic [7:0] OFS_FPAT0 = 8'h10;
   localparam logic [7:0] OFS_FPAT1 = 8'h14;
   localparam logic [7:0] OFS_FPAT2 = 8'h18;
   localparam logic [7:0] OFS_FPAT3 = 8'h1c;
   localparam logic [7:0] OFS_PAT_ADDR = 8'h20;
   localparam logic [7:0] OFS_PAT_DATA = 8'h24;
   localparam logic [7:0] OFS_CMD = 8'h28;
   localparam logic [7:0] OFS_STATUS = 8'h2c;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h30;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h34;
   localparam logic [7:0] OFS_CNT_A = 8'h38;
   localparam logic [7:0] OFS_CNT_B = 8'h3c;
   localparam logic [7:0] OFS_CNT_C = 8'h40;
   localparam logic [7:0] OFS_BIT_COUNT = 8'h44;
   localparam logic [7:0] OFS_CLK_COUNT = 8'h48;
   localparam logic [7:0] OFS_FREQ_KHZ = 8'h4c;
   localparam logic [7:0] OFS_EI_COUNT = 8'h50;
   localparam logic [7:0] OFS_IVL_COUNT = 8'h54;
   localparam logic [7:0] OFS_SL_IVL = 8'h58;
   localparam logic [7:0] OFS_CL_IVL = 8'h5c;
   localparam logic [7:0] OFS_EFF_POS = 8'h60;
   localparam logic [7:0] OFS_EFF_LEN = 8'h64;

   localparam int CTRL_EN = 0;
   localparam int CTRL_TYPE_LSB = 1;
   localparam int CTRL_QUICK = 3;
   localparam int CTRL_FLEN_LSB = 4;
   localparam int CTRL_COMB = 8;
   localparam int CTRL_TRANS = 9;
   localparam logic [15:0] CTRL_RESET = 16'h0000;

   localparam int CMD_HIST_CLR = 0;
   localparam int CMD_CNT_CLR = 1;

   localparam int EV_SYNC_GAIN = 0;
   localparam int EV_SYNC_LOSS = 1;
   localparam int EV_CLK_LOSS = 2;
   localparam int EV_ERROR = 3;

   localparam int ST_CUR_CL = 0;
   localparam int ST_CUR_SL = 1;
   localparam int ST_CUR_ER = 2;
   localparam int ST_HIS_LSB = 3;
   localparam int ST_BAD_MODE = 6;
   localparam int ST_IN_SYNC = 7;

   typedef enum logic [1:0] {PT_PRBS, PT_ZERO_RUN, PT_DATA, PT_MIXED} psm_pat_t;

endpackage : psm_pkg

//--- dv/psm_checker.sv
// Port-level assertions for the pattern monitor.
`timescale 1ns/1ns
module psm_checker (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic irq
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence s_acc;
      psel && penable && !pready;
   endsequence
   sequence s_bad;
      s_acc ##0 (paddr > 8'h64 || paddr[1:0] != 2'h0);
   endsequence
   property p_wait;
      s_acc |=> pready;
   endproperty
   a_wait: assert property (p_wait) else $error("access not answered after one wait state");
   property p_pulse;
      pready |=> !pready;
   endproperty
   a_pulse: assert property (p_pulse) else $error("ready held longer than one cycle");
   property p_inacc;
      pready |-> psel && penable;
   endproperty
   a_inacc: assert property (p_inacc) else $error("ready outside an access");
   property p_errrdy;
      pslverr |-> pready;
   endproperty
   a_errrdy: assert property (p_errrdy) else $error("error flag without ready");
   property p_bad;
      s_bad |=> pslverr;
   endproperty
   a_bad: assert property (p_bad) else $error("unmapped access not refused");
   property p_good;
      s_acc ##0 (paddr <= 8'h64 && paddr[1:0] == 2'h0) |=> !pslverr;
   endproperty
   a_good: assert property (p_good) else $error("mapped access refused");
   property p_badrd;
      pslverr && !pwrite |-> prdata == 32'h0;
   endproperty
   a_badrd: assert property (p_badrd) else $error("refused read returned data");
   property p_rst;
      $fell(rst) |-> !irq && !pready;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs active right after reset");
endmodule : psm_checker

//--- dv/psm_link_model.sv
// Link source that streams a repeating pattern on a clock gated by run.
`timescale 1ns/1ns
module psm_link_model (
   input wire logic run,
   input wire logic flip,
   input wire logic [63:0] pat,
   output logic rx_clk,
   output logic rx_data,
   output logic flip_ref
);
   int idx;
   initial begin
      rx_clk = 1'b0;
      rx_data = 1'b0;
      flip_ref = 1'b0;
      idx = 0;
      forever begin
         if (run) begin
            rx_data = pat[idx] ^ flip;
            if (flip) begin
               flip_ref = pat[idx];
            end
            idx = (idx + 1) % 64;
            #62 rx_clk = 1'b1;
            #63 rx_clk = 1'b0;
         end else begin
            // The clock stands still and the idle line toggles so no stale level looks valid.
            rx_data = ~rx_data;
            #125;
         end
      end
   end
endmodule : psm_link_model

//--- dv/tb.sv
// Self-checking bench for the pattern monitor.
`timescale 1ns/1ns
module tb;
   import psm_pkg::*;
   localparam logic [63:0] PAT = {32'hc3a5_5a3c, 32'hf0e1_0001};
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic rx_clk;
   logic rx_data;
   logic irq;
   logic run = 1'b0;
   logic flip = 1'b0;
   logic flip_ref;
   logic [31:0] q;
   logic e;
   logic [31:0] t;
   int miscompares = 0;
   int samples_checked = 0;
   // Each row is a control word and the mode-invalid flag it should give.
   logic [32:0] rows [8] = '{{32'h31, 1'b1}, {32'h39, 1'b1}, {32'h33, 1'b0}, {32'h3b, 1'b0},
      {32'h35, 1'b0}, {32'h3d, 1'b0}, {32'h37, 1'b0}, {32'h3f, 1'b1}};
   always #5 ref_clk = ~ref_clk;
   psm_monitor #(.INTERVAL_CYCLES(200)) psm_monitor_inst (.ref_clk(ref_clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rx_clk(rx_clk), .rx_data(rx_data), .irq(irq));
   psm_link_model psm_link_model_inst (.run(run), .flip(flip), .pat(PAT), .rx_clk(rx_clk),
      .rx_data(rx_data), .flip_ref(flip_ref));
   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : final_report
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         miscompares++;
         final_report();
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic poll(input logic [7:0] a, input int b);
      int n;
      n = 0;
      do begin
         apb(1'b0, a, 32'h0);
         n++;
      end while (q[b] !== 1'b1 && n < 3000);
      chk(32'(q[b]), 32'h1);
   endtask : poll
   initial begin
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      apb(1'b0, OFS_CTRL, 32'h0);
      chk(q, 32'(CTRL_RESET));
      apb(1'b0, OFS_IRQ_STAT, 32'h0);
      chk(q, 32'h0);
      chk(32'(irq), 32'h0);
      apb(1'b1, 8'h68, 32'h1);
      chk(32'(e), 32'h1);
      apb(1'b0, 8'h06, 32'h0);
      chk({31'h0, e} | q, 32'h1);
      apb(1'b1, OFS_CLK_COUNT, 32'h1234);
      chk(32'(e), 32'h0);
      apb(1'b0, OFS_CLK_COUNT, 32'h0);
      chk(q, 32'h0);
      apb(1'b1, OFS_PAT_LEN, 32'd64);
      apb(1'b1, OFS_PAT_ADDR, 32'h0);
      apb(1'b1, OFS_PAT_DATA, PAT[31:0]);
      apb(1'b1, OFS_PAT_DATA, PAT[63:32]);
      apb(1'b1, OFS_FPAT0, 32'h8000);
      apb(1'b1, OFS_FRAME_POS, 32'h1);
      apb(1'b0, OFS_FRAME_POS, 32'h0);
      chk(q, 32'h1);
      apb(1'b1, OFS_IRQ_MASK, 32'h1);
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, OFS_CTRL, rows[i][32:1]);
         apb(1'b0, OFS_STATUS, 32'h0);
         chk(32'(q[ST_BAD_MODE]), 32'(rows[i][0]));
      end
      run <= 1'b1;
      for (int m = 0; m < 2; m++) begin
         apb(1'b1, OFS_CTRL, 32'h0);
         apb(1'b0, OFS_IRQ_STAT, 32'h0);
         apb(1'b1, OFS_CTRL, (m == 1) ? 32'h33 : 32'h3d);
         poll(OFS_STATUS, ST_IN_SYNC);
         chk(32'(irq), 32'h1);
         apb(1'b0, OFS_IRQ_STAT, 32'h0);
         chk(32'(q[EV_SYNC_GAIN]), 32'h1);
         repeat (2) @(posedge ref_clk);
         chk(32'(irq), 32'h0);
      end
      apb(1'b0, OFS_EFF_LEN, 32'h0);
      chk(q, 32'(MIN_EFF_LEN));
      apb(1'b0, OFS_EFF_POS, 32'h0);
      chk(q, 32'h1);
      apb(1'b1, OFS_CMD, 32'h3);
      repeat (300) @(posedge ref_clk);
      apb(1'b0, OFS_CNT_A, 32'h0);
      chk(q, 32'h0);
      @(posedge rx_clk);
      flip <= 1'b1;
      @(posedge rx_clk);
      flip <= 1'b0;
      repeat (500) @(posedge ref_clk);
      apb(1'b0, OFS_CNT_A, 32'h0);
      chk(q, 32'h1);
      apb(1'b0, OFS_CNT_B, 32'h0);
      chk(q, 32'(!flip_ref));
      apb(1'b0, OFS_CNT_C, 32'h0);
      chk(q, 32'(flip_ref));
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(32'(q[ST_HIS_LSB + 2]), 32'h1);
      apb(1'b1, OFS_CMD, 32'h1);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(32'(q[ST_HIS_LSB + 2]), 32'h0);
      chk(32'(q[ST_IN_SYNC]), 32'h1);
      apb(1'b0, OFS_EI_COUNT, 32'h0);
      chk(q, 32'h1);
      apb(1'b0, OFS_IVL_COUNT, 32'h0);
      chk(32'(q > 32'h1), 32'h1);
      apb(1'b0, OFS_FREQ_KHZ, 32'h0);
      chk(32'(q >= 32'd15 && q <= 32'd17), 32'h1);
      apb(1'b1, OFS_CTRL, 32'h233);
      apb(1'b0, OFS_CNT_A, 32'h0);
      t = q;
      apb(1'b0, OFS_CNT_B, 32'h0);
      chk(t + q, 32'h1);
      apb(1'b0, OFS_CNT_C, 32'h0);
      chk(q, 32'h0);
      apb(1'b0, OFS_SL_IVL, 32'h0);
      t = q;
      @(posedge rx_clk);
      flip <= 1'b1;
      repeat (40) @(posedge rx_clk);
      flip <= 1'b0;
      poll(OFS_IRQ_STAT, EV_SYNC_LOSS);
      poll(OFS_STATUS, ST_IN_SYNC);
      apb(1'b0, OFS_IRQ_STAT, 32'h0);
      chk(32'(q[EV_SYNC_GAIN]), 32'h1);
      run <= 1'b0;
      poll(OFS_STATUS, ST_CUR_CL);
      chk(32'(irq), 32'h0);
      apb(1'b0, OFS_IRQ_STAT, 32'h0);
      chk(32'(q[EV_CLK_LOSS]), 32'h1);
      repeat (400) @(posedge ref_clk);
      apb(1'b0, OFS_CL_IVL, 32'h0);
      chk(32'(q != 32'h0), 32'h1);
      apb(1'b0, OFS_SL_IVL, 32'h0);
      chk(32'(q > t), 32'h1);
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(32'(q[ST_IN_SYNC]), 32'h0);
      apb(1'b1, OFS_ROW_LEN, 32'h64);
      apb(1'b1, OFS_FRAME_POS, 32'hfff);
      apb(1'b1, OFS_CTRL, 32'h1f6);
      repeat (12) @(posedge ref_clk);
      apb(1'b0, OFS_EFF_LEN, 32'h0);
      chk(q, 32'h258);
      apb(1'b0, OFS_EFF_POS, 32'h0);
      chk(q, 32'h219);
      apb(1'b1, OFS_FRAME_POS, 32'h5);
      apb(1'b0, OFS_EFF_POS, 32'h0);
      chk(q, 32'h5);
      final_report();
   end
endmodule : tb
bind psm_monitor psm_checker psm_checker_inst (.ref_clk(ref_clk), .rst(rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .irq(irq));

//--- rtl/psm_monitor.sv
// Pattern synchroniser, error counters and alarm monitor behind an APB slave.
`timescale 1ns/1ns
module psm_monitor
   import psm_pkg::*;
#(
   parameter int INTERVAL_CYCLES = INTERVAL_CYC
)
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_clk,
   input wire logic rx_data,
   output logic irq
);

   typedef enum logic [1:0] {S_IDLE, S_SEARCH, S_SYNC} psm_sync_t;

   typedef struct packed {
      logic clk_s1;
      logic clk_s2;
      logic clk_s3;
      logic dat_s1;
      logic dat_s2;
      logic [15:0] ctrl;
      logic [11:0] frame_pos;
      logic [11:0] pat_len;
      logic [11:0] row_len;
      logic [127:0] frame_pat;
      logic [5:0] pat_addr;
      logic [12:0] eff_len;
      logic [11:0] eff_pos;
      psm_sync_t st;
      logic [127:0] shreg;
      logic [7:0] match_cnt;
      logic [7:0] win_cnt;
      logic [7:0] win_err;
      logic [11:0] ptr;
      logic prev_ref;
      logic [31:0] c_tot;
      logic [31:0] c_ins;
      logic [31:0] c_omi;
      logic [31:0] c_tr;
      logic [31:0] c_ntr;
      logic [31:0] c_bits;
      logic [31:0] c_clk;
      logic [31:0] edge_cnt;
      logic [31:0] freq;
      logic [31:0] c_ei;
      logic [31:0] c_ivl;
      logic [31:0] c_sli;
      logic [31:0] c_cli;
      logic [31:0] ivl_tmr;
      logic ivl_err;
      logic ivl_sl;
      logic ivl_cl;
      logic err_cur;
      logic [15:0] loss_tmr;
      logic clk_loss;
      logic [2:0] hist;
      logic [3:0] irq_stat;
      logic [3:0] irq_mask;
      logic pready;
      logic pslverr;
      logic irq;
      logic [31:0] prdata;
   } psm_state_t;

   psm_state_t s_r;
   psm_state_t s_nxt;

   logic [6:0] flen;
   logic [7:0] det_bits;
   logic [127:0] det_mask;
   logic [31:0] mem_rdata;
   logic mem_we;

   logic rx_edge;
   logic rx_bit;
   logic ref_bit;
   logic err;
   logic trans;
   logic quick;
   logic comb2;
   logic mode_ok;
   logic cfg_wr;
   logic cur_sl;
   logic ivl_end;
   logic acc;
   logic wr_fire;
   logic rd_fire;
   logic mapped;
   logic [31:0] rd_word;
   logic [11:0] base_len;
   logic [12:0] lim;
   logic [11:0] req;
   logic [3:0] ev;
   logic [2:0] hist_set;
   psm_pat_t ptype;

   function automatic logic [11:0] psm_wrap(input logic [12:0] v, input logic [11:0] len);
      logic [12:0] d;
      d = v - {1'b0, len};
      return (v >= {1'b0, len}) ? d[11:0] : v[11:0];
   endfunction : psm_wrap

   assign flen = 7'(({3'b000, s_r.ctrl[CTRL_FLEN_LSB +: 4]} + 7'd1) << 2);
   assign det_bits = s_r.ctrl[CTRL_COMB] ? {flen, 1'b0} : {1'b0, flen};

   genvar gi;
   for (gi = 0; gi < 128; gi++) begin : g_mask
      assign det_mask[gi] = (8'(gi) < det_bits);
   end

   assign mem_we = psel & penable & pwrite & s_r.pready & (paddr == OFS_PAT_DATA);

   psm_pat_mem u_mem (
      .ref_clk(ref_clk),
      .wr_en(mem_we),
      .wr_addr(s_r.pat_addr),
      .wr_data(pwdata),
      .rd_addr(s_r.ptr[10:5]),
      .rd_data(mem_rdata)
   );

   always_comb begin
      s_nxt = s_r;
      ev = 4'h0;
      hist_set = 3'b000;
      err = 1'b0;
      trans = 1'b0;
      lim = 13'd0;
      req = 12'd0;
      rd_word = 32'h0000_0000;
      mapped = 1'b1;

      // Link data passes two flops and the clock three; edges are found on the second and third stages.
      s_nxt.clk_s1 = rx_clk;
      s_nxt.clk_s2 = s_r.clk_s1;
      s_nxt.clk_s3 = s_r.clk_s2;
      s_nxt.dat_s1 = rx_data;
      s_nxt.dat_s2 = s_r.dat_s1;
      rx_edge = s_r.clk_s2 & ~s_r.clk_s3;
      rx_bit = s_r.dat_s2;
      ref_bit = mem_rdata[s_r.ptr[4:0]];

      ptype = psm_pat_t'(s_r.ctrl[CTRL_TYPE_LSB +: 2]);
      quick = s_r.ctrl[CTRL_QUICK];
      comb2 = s_r.ctrl[CTRL_COMB];
      mode_ok = (ptype != PT_PRBS) && !(ptype == PT_MIXED && quick);
      base_len = (ptype == PT_MIXED) ? s_r.row_len : s_r.pat_len;

      acc = psel & penable;
      wr_fire = acc & pwrite & s_r.pready;
      rd_fire = acc & ~pwrite & s_r.pready;
      cfg_wr = wr_fire && (paddr == OFS_CTRL || paddr == OFS_PAT_LEN || paddr == OFS_ROW_LEN);

      // Effective length grows by whole pattern lengths (row lengths in mixed mode) until it reaches 512.
      if (cfg_wr) begin
         s_nxt.eff_len = 13'd0;
      end else if (s_r.eff_len < MIN_EFF_LEN && base_len != 12'd0) begin
         s_nxt.eff_len = s_r.eff_len + {1'b0, base_len};
      end

      if (comb2) begin
         lim = (s_r.eff_len > {6'd0, flen}) ? ((s_r.eff_len - {6'd0, flen}) >> 1) : 13'd0;
         req = (s_r.frame_pos > 12'd0) ? ((s_r.frame_pos - 12'd1) >> 1) : 12'd0;
         if ({1'b0, req} > lim) begin
            req = lim[11:0];
         end
         s_nxt.eff_pos = 12'd1 + {req[10:0], 1'b0};
      end else begin
         lim = (s_r.eff_len > {6'd0, flen} + 13'd1) ? (s_r.eff_len - {6'd0, flen} - 13'd1) : 13'd1;
         if (s_r.frame_pos == 12'd0) begin
            s_nxt.eff_pos = 12'd1;
         end else if ({1'b0, s_r.frame_pos} > lim) begin
            s_nxt.eff_pos = lim[11:0];
         end else begin
            s_nxt.eff_pos = s_r.frame_pos;
         end
      end

      case (s_r.st)
         S_IDLE: begin
            if (s_r.ctrl[CTRL_EN] && mode_ok) begin
               s_nxt.st = S_SEARCH;
               s_nxt.match_cnt = 8'd0;
               s_nxt.shreg = '0;
            end
         end
         S_SEARCH: begin
            if (!s_r.ctrl[CTRL_EN] || !mode_ok) begin
               s_nxt.st = S_IDLE;
            end else if (rx_edge) begin
               s_nxt.shreg = {s_r.shreg[126:0], rx_bit};
               if (!quick) begin
                  if (((s_nxt.shreg ^ s_r.frame_pat) & det_mask) == '0) begin
                     s_nxt.st = S_SYNC;
                     s_nxt.ptr = psm_wrap({1'b0, s_r.eff_pos} - 13'd1 + {5'd0, det_bits}, base_len);
                     ev[EV_SYNC_GAIN] = 1'b1;
                  end
               end else if (rx_bit == ref_bit) begin
                  s_nxt.ptr = psm_wrap({1'b0, s_r.ptr} + 13'd1, base_len);
                  s_nxt.match_cnt = s_r.match_cnt + 8'd1;
                  if (s_r.match_cnt == QUICK_GAIN_BITS - 8'd1) begin
                     s_nxt.st = S_SYNC;
                     ev[EV_SYNC_GAIN] = 1'b1;
                  end
               end else begin
                  // A mismatch slips the reference by one bit and restarts the run.
                  s_nxt.ptr = psm_wrap({1'b0, s_r.ptr} + 13'd2, base_len);
                  s_nxt.match_cnt = 8'd0;
               end
               s_nxt.prev_ref = ref_bit;
               s_nxt.win_cnt = 8'd0;
               s_nxt.win_err = 8'd0;
            end
         end
         S_SYNC: begin
            if (!s_r.ctrl[CTRL_EN] || !mode_ok) begin
               s_nxt.st = S_IDLE;
            end else if (rx_edge) begin
               err = rx_bit ^ ref_bit;
               trans = ref_bit ^ s_r.prev_ref;
               s_nxt.prev_ref = ref_bit;
               s_nxt.ptr = psm_wrap({1'b0, s_r.ptr} + 13'd1, base_len);
               s_nxt.c_bits = s_r.c_bits + 32'd1;
               if (err) begin
                  s_nxt.c_tot = s_r.c_tot + 32'd1;
                  if (rx_bit) begin
                     s_nxt.c_ins = s_r.c_ins + 32'd1;
                  end else begin
                     s_nxt.c_omi = s_r.c_omi + 32'd1;
                  end
                  if (trans) begin
                     s_nxt.c_tr = s_r.c_tr + 32'd1;
                  end else begin
                     s_nxt.c_ntr = s_r.c_ntr + 32'd1;
                  end
                  ev[EV_ERROR] = 1'b1;
               end
               s_nxt.win_cnt = s_r.win_cnt + 8'd1;
               s_nxt.win_err = s_r.win_err + {7'd0, err};
               if (s_r.win_cnt == SYNC_WIN_BITS - 8'd1) begin
                  s_nxt.win_cnt = 8'd0;
                  // The window total is judged before the count restarts for the next window.
                  if (s_nxt.win_err >= SYNC_LOSS_ERRS) begin
                     s_nxt.st = S_SEARCH;
                     s_nxt.match_cnt = 8'd0;
                     ev[EV_SYNC_LOSS] = 1'b1;
                  end
                  s_nxt.win_err = 8'd0;
               end
            end
         end
         default: begin
            s_nxt.st = S_IDLE;
         end
      endcase

      // Input clock supervision and clock tally.
      if (rx_edge) begin
         s_nxt.c_clk = s_r.c_clk + 32'd1;
         s_nxt.edge_cnt = s_r.edge_cnt + 32'd1;
         s_nxt.loss_tmr = 16'd0;
         s_nxt.clk_loss = 1'b0;
      end else if (s_r.loss_tmr == 16'(CLK_LOSS_CYC - 1)) begin
         s_nxt.clk_loss = 1'b1;
         ev[EV_CLK_LOSS] = ~s_r.clk_loss;
      end else begin
         s_nxt.loss_tmr = s_r.loss_tmr + 16'd1;
      end

      cur_sl = s_r.ctrl[CTRL_EN] && (s_r.st != S_SYNC);
      s_nxt.ivl_err = s_r.ivl_err | err;
      s_nxt.ivl_sl = s_r.ivl_sl | cur_sl;
      s_nxt.ivl_cl = s_r.ivl_cl | s_r.clk_loss;
      s_nxt.err_cur = s_r.err_cur | err;

      // Measurement interval; edges per millisecond give the frequency in kHz.
      ivl_end = (s_r.ivl_tmr == 32'(INTERVAL_CYCLES - 1));
      s_nxt.ivl_tmr = ivl_end ? 32'd0 : s_r.ivl_tmr + 32'd1;
      if (ivl_end) begin
         s_nxt.c_ivl = s_r.c_ivl + 32'd1;
         s_nxt.freq = s_nxt.edge_cnt;
         s_nxt.edge_cnt = 32'd0;
         if (s_r.ivl_err | err) begin
            s_nxt.c_ei = s_r.c_ei + 32'd1;
         end
         if (s_r.ivl_sl | cur_sl) begin
            s_nxt.c_sli = s_r.c_sli + 32'd1;
         end
         if (s_r.ivl_cl | s_r.clk_loss) begin
            s_nxt.c_cli = s_r.c_cli + 32'd1;
         end
         s_nxt.err_cur = s_r.ivl_err | err;
         s_nxt.ivl_err = 1'b0;
         s_nxt.ivl_sl = 1'b0;
         s_nxt.ivl_cl = 1'b0;
      end

      hist_set = {err, cur_sl, s_r.clk_loss};

      // APB read decode.
      case (paddr)
         OFS_CTRL: rd_word = {16'h0000, s_r.ctrl};
         OFS_FRAME_POS: rd_word = {20'h00000, s_r.frame_pos};
         OFS_PAT_LEN: rd_word = {20'h00000, s_r.pat_len};
         OFS_ROW_LEN: rd_word = {20'h00000, s_r.row_len};
         OFS_FPAT0: rd_word = s_r.frame_pat[31:0];
         OFS_FPAT1: rd_word = s_r.frame_pat[63:32];
         OFS_FPAT2: rd_word = s_r.frame_pat[95:64];
         OFS_FPAT3: rd_word = s_r.frame_pat[127:96];
         OFS_PAT_ADDR: rd_word = {26'h0000000, s_r.pat_addr};
         OFS_PAT_DATA: rd_word = 32'h0000_0000;
         OFS_CMD: rd_word = 32'h0000_0000;
         OFS_STATUS: rd_word = {24'h000000, s_r.st == S_SYNC, ~mode_ok, s_r.hist,
                                s_r.err_cur, cur_sl, s_r.clk_loss};
         OFS_IRQ_STAT: rd_word = {28'h0000000, s_r.irq_stat};
         OFS_IRQ_MASK: rd_word = {28'h0000000, s_r.irq_mask};
         OFS_CNT_A: rd_word = s_r.ctrl[CTRL_TRANS] ? s_r.c_tr : s_r.c_tot;
         OFS_CNT_B: rd_word = s_r.ctrl[CTRL_TRANS] ? s_r.c_ntr : s_r.c_ins;
         OFS_CNT_C: rd_word = s_r.ctrl[CTRL_TRANS] ? 32'h0000_0000 : s_r.c_omi;
         OFS_BIT_COUNT: rd_word = s_r.c_bits;
         OFS_CLK_COUNT: rd_word = s_r.c_clk;
         OFS_FREQ_KHZ: rd_word = s_r.freq;
         OFS_EI_COUNT: rd_word = s_r.c_ei;
         OFS_IVL_COUNT: rd_word = s_r.c_ivl;
         OFS_SL_IVL: rd_word = s_r.c_sli;
         OFS_CL_IVL: rd_word = s_r.c_cli;
         OFS_EFF_POS: rd_word = {20'h00000, s_r.eff_pos};
         OFS_EFF_LEN: rd_word = {19'h00000, s_r.eff_len};
         default: mapped = 1'b0;
      endcase

      // One wait state: data and pready come from flops in the second access cycle.
      s_nxt.pready = acc & ~s_r.pready;
      if (acc & ~s_r.pready) begin
         s_nxt.prdata = pwrite ? 32'h0000_0000 : rd_word;
         s_nxt.pslverr = ~mapped;
      end else begin
         s_nxt.pslverr = 1'b0;
      end

      if (wr_fire) begin
         case (paddr)
            OFS_CTRL: s_nxt.ctrl = pwdata[15:0];
            OFS_FRAME_POS: s_nxt.frame_pos = pwdata[11:0];
            OFS_PAT_LEN: s_nxt.pat_len = pwdata[11:0];
            OFS_ROW_LEN: s_nxt.row_len = pwdata[11:0];
            OFS_FPAT0: s_nxt.frame_pat[31:0] = pwdata;
            OFS_FPAT1: s_nxt.frame_pat[63:32] = pwdata;
            OFS_FPAT2: s_nxt.frame_pat[95:64] = pwdata;
            OFS_FPAT3: s_nxt.frame_pat[127:96] = pwdata;
            OFS_PAT_ADDR: s_nxt.pat_addr = pwdata[5:0];
            OFS_PAT_DATA: s_nxt.pat_addr = s_r.pat_addr + 6'd1;
            OFS_IRQ_MASK: s_nxt.irq_mask = pwdata[3:0];
            OFS_CMD: begin
               if (pwdata[CMD_CNT_CLR]) begin
                  s_nxt.c_tot = 32'd0;
                  s_nxt.c_ins = 32'd0;
                  s_nxt.c_omi = 32'd0;
                  s_nxt.c_tr = 32'd0;
                  s_nxt.c_ntr = 32'd0;
                  s_nxt.c_bits = 32'd0;
                  s_nxt.c_clk = 32'd0;
                  s_nxt.c_ei = 32'd0;
                  s_nxt.c_ivl = 32'd0;
                  s_nxt.c_sli = 32'd0;
                  s_nxt.c_cli = 32'd0;
               end
            end
            default: begin
            end
         endcase
      end

      // History clears only on command; a condition in the same cycle still latches.
      if (wr_fire && paddr == OFS_CMD && pwdata[CMD_HIST_CLR]) begin
         s_nxt.hist = hist_set;
      end else begin
         s_nxt.hist = s_r.hist | hist_set;
      end

      // Sticky events: a read clears only what it reported, new events win.
      s_nxt.irq_stat = s_r.irq_stat | ev;
      if (rd_fire && paddr == OFS_IRQ_STAT) begin
         s_nxt.irq_stat = (s_r.irq_stat & ~s_r.prdata[3:0]) | ev;
      end
      s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s_r <= psm_state_t'('0);
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prdata = s_r.prdata;
   assign pready = s_r.pready;
   assign pslverr = s_r.pslverr;
   assign irq = s_r.irq;

endmodule : psm_monitor

//--- rtl/psm_pat_mem.sv
// Reference pattern memory with a registered read port.
`timescale 1ns/1ns
module psm_pat_mem
   import psm_pkg::*;
(
   input wire logic ref_clk,
   input wire logic wr_en,
   input wire logic [PAT_AW-1:0] wr_addr,
   input wire logic [31:0] wr_data,
   input wire logic [PAT_AW-1:0] rd_addr,
   output logic [31:0] rd_data
);

   logic [31:0] mem [PAT_WORDS];

   always_ff @(posedge ref_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end

endmodule : psm_pat_mem
